// File: logic/scsc_top.sv
// The strobed register port was chosen for this implementation.
`timescale 1ns/1ns
module scsc_top
  import scsc_pkg::*;
#(
  parameter int WUP_LONG_CYC  = SCSC_WUP_LONG,
  parameter int WUP_MID_CYC   = SCSC_WUP_MID,
  parameter int WUP_SHORT_CYC = SCSC_WUP_SHORT
) (
  // Clock and reset
  input  wire logic       clk_sys_in,
  input  wire logic       rst_n_in,
  // Register port
  input  wire logic [7:0] reg_addr_in,
  input  wire logic [7:0] reg_wdata_in,
  input  wire logic       reg_wr_in,
  input  wire logic       reg_rd_in,
  output logic      [7:0] reg_rdata_out,
  // External and core signals
  input  wire logic       stop_release_pin_in,
  input  wire logic       irq_in,
  input  wire logic       master_interrupt_enable_in,
  // Mode outputs
  output logic      [1:0] mode_out,
  output logic            cpu_run_out,
  output logic            wdt_run_out,
  output logic            periph_run_out,
  output logic            osc_enable_out,
  output logic            port_hiz_out,
  output logic            service_irq_out,
  output logic            resume_next_out,
  // Timing generator outputs
  output logic      [1:0] machine_state_out,
  output logic            divider_output_pulse_out,
  output logic            tb_src_out,
  output logic            wdt_src_out,
  output logic            tmr_src_out,
  output logic            warmup_clk_out
);

  // ------------------------------------------------------------
  // State
  // ------------------------------------------------------------
  typedef struct packed {
    scsc_mode_e              mode;
    logic [SCSC_CHAIN_W-1:0] chain;
    logic [1:0]              mstate;
    logic [7:0]              tbdiv;
    logic [7:0]              sby1;
    logic [7:0]              sby2;
    logic [7:0]              divctl;
    logic                    pin_prev;
    logic [7:0]              rdata;
    logic                    divider_output_pulse;
    logic                    tb_src;
    logic                    wdt_src;
    logic                    tmr_src;
    logic                    wup_clk;
    logic                    svc;
    logic                    resume;
  } scsc_state_s;

  scsc_state_s q;
  scsc_state_s d;

  logic [SCSC_CHAIN_W-1:0] wup_base;
  logic [SCSC_CHAIN_W-1:0] wup_target;
  logic                    pin_rise;
  logic                    release_ok;
  logic                    clocks_run;
  logic [1:0]              dvo_rate;
  logic [2:0]              tb_rate;

  // A stage ticks when every bit below and at it is one
  function automatic logic scsc_tap(input logic [SCSC_CHAIN_W-1:0] chain,
                                    input int                      stage);
    logic [SCSC_CHAIN_W-1:0] mask;
    mask = '1;
    mask = mask >> (SCSC_CHAIN_W - 1 - stage);
    return (chain & mask) == mask;
  endfunction

  // ------------------------------------------------------------
  // Warm-up length
  // ------------------------------------------------------------
  always_comb begin
    case (q.sby1[SCSC_SBY1_WUT +: 2])
      2'b00:   wup_base = SCSC_CHAIN_W'(WUP_LONG_CYC);
      2'b01:   wup_base = SCSC_CHAIN_W'(WUP_MID_CYC);
      2'b10:   wup_base = SCSC_CHAIN_W'(WUP_SHORT_CYC);
      // Reserved code falls back to the longest, safest wait
      default: wup_base = SCSC_CHAIN_W'(WUP_LONG_CYC);
    endcase
    wup_target = q.divctl[SCSC_DIV_STAGE] ? (wup_base << 1) : wup_base;
  end

  assign pin_rise   = stop_release_pin_in & ~q.pin_prev;
  assign release_ok = q.sby1[SCSC_SBY1_RELSEL] ? stop_release_pin_in
                                                : pin_rise;
  assign clocks_run = (q.mode == SCSC_NORMAL) || (q.mode == SCSC_IDLE);
  assign dvo_rate   = q.tbdiv[SCSC_TB_DVORATE +: 2];
  assign tb_rate    = q.tbdiv[SCSC_TB_RATE +: 3];

  // ------------------------------------------------------------
  // Next state
  // ------------------------------------------------------------
  always_comb begin
    d          = q;
    d.pin_prev = stop_release_pin_in;
    d.rdata    = 8'h00;
    d.svc      = 1'b0;
    d.resume   = 1'b0;
    d.wup_clk  = 1'b0;

    // Oscillator is off in stop, so the whole chain freezes there
    if (q.mode != SCSC_STOP) begin
      d.chain = q.chain + 1'b1;
    end

    // One state per fc period, four states per machine cycle
    // The core spends one to fifteen such cycles on an instruction
    if (clocks_run) begin
      d.mstate = q.mstate + 2'h1;
    end

    // Source clocks, each a one-cycle enable from a divider stage; the divider output toggles on its stage instead
    d.tb_src  = clocks_run && q.tbdiv[SCSC_TB_EN] &&
                scsc_tap(q.chain, SCSC_TAP_TB + int'(tb_rate));
    d.wdt_src = (q.mode == SCSC_NORMAL) && scsc_tap(q.chain, SCSC_TAP_WDT);
    d.tmr_src = clocks_run && scsc_tap(q.chain, SCSC_TAP_TMR);
    if (!q.tbdiv[SCSC_TB_DIVIDER_OUTPUT_ENABLE]) begin
      d.divider_output_pulse = 1'b0;
    end else if (clocks_run && scsc_tap(q.chain, SCSC_TAP_DVO + int'(dvo_rate))) begin
      d.divider_output_pulse = ~q.divider_output_pulse;
    end

    // --------------------------------------------------------
    // Mode sequencer
    // --------------------------------------------------------
    case (q.mode)
      SCSC_NORMAL: begin
        if (q.sby1[SCSC_SBY1_STOP]) begin
          d.chain = '0;
          if (q.sby1[SCSC_SBY1_RELSEL] && stop_release_pin_in) begin
            d.mode                 = SCSC_WARMUP;
            d.sby1[SCSC_SBY1_STOP] = 1'b0;
          end else begin
            d.mode = SCSC_STOP;
          end
        end else if (q.sby2[SCSC_SBY2_IDLE]) begin
          d.mode = SCSC_IDLE;
        end
      end
      SCSC_IDLE: begin
        if (irq_in) begin
          d.mode                 = SCSC_NORMAL;
          d.sby2[SCSC_SBY2_IDLE] = 1'b0;
          d.svc                  = master_interrupt_enable_in;
          d.resume               = ~master_interrupt_enable_in;
        end
      end
      SCSC_STOP: begin
        // Edge detection keeps sampling so a rising edge is seen here
        if (release_ok) begin
          d.mode                 = SCSC_WARMUP;
          d.chain                = '0;
          d.sby1[SCSC_SBY1_STOP] = 1'b0;
        end
      end
      SCSC_WARMUP: begin
        d.wup_clk = 1'b1;
        // Once warm-up runs, a low pin does not send us back to stop
        if (q.chain == wup_target - 1'b1) begin
          // Return mode one is reserved, so release always goes to normal
          d.mode   = SCSC_NORMAL;
          d.chain  = '0;
          d.mstate = 2'h0;
          d.resume = 1'b1;
        end
      end
      default: begin
        d.mode = SCSC_NORMAL;
      end
    endcase

    // --------------------------------------------------------
    // Register port
    // --------------------------------------------------------
    // Writes come last so a set in the same cycle wins over a clear
    if (reg_wr_in) begin
      case (reg_addr_in)
        SCSC_ADDR_DIVCTL: d.divctl = reg_wdata_in & SCSC_WM_DIVCTL;
        SCSC_ADDR_TBDIV:  d.tbdiv  = reg_wdata_in & SCSC_WM_TBDIV;
        SCSC_ADDR_SBY1:   d.sby1   = reg_wdata_in & SCSC_WM_SBY1;
        SCSC_ADDR_SBY2:   d.sby2   = reg_wdata_in & SCSC_WM_SBY2;
        default: begin
        end
      endcase
    end

    if (reg_rd_in) begin
      case (reg_addr_in)
        SCSC_ADDR_DIVCTL: d.rdata = q.divctl & SCSC_RM_DIVCTL;
        SCSC_ADDR_TBDIV:  d.rdata = q.tbdiv;
        SCSC_ADDR_SBY1:   d.rdata = q.sby1 & SCSC_RM_SBY1;
        SCSC_ADDR_SBY2:   d.rdata = q.sby2 & SCSC_RM_SBY2;
        default:          d.rdata = 8'h00;
      endcase
    end
  end

  // ------------------------------------------------------------
  // Registers
  // ------------------------------------------------------------
  always_ff @(posedge clk_sys_in) begin
    if (!rst_n_in) begin
      q.mode     <= SCSC_NORMAL;
      q.chain    <= '0;
      q.mstate   <= 2'h0;
      q.tbdiv    <= SCSC_RST_TBDIV;
      q.sby1     <= SCSC_RST_SBY1;
      q.sby2     <= SCSC_RST_SBY2;
      q.divctl   <= SCSC_RST_DIVCTL;
      q.pin_prev <= 1'b0;
      q.rdata    <= 8'h00;
      q.divider_output_pulse      <= 1'b0;
      q.tb_src   <= 1'b0;
      q.wdt_src  <= 1'b0;
      q.tmr_src  <= 1'b0;
      q.wup_clk  <= 1'b0;
      q.svc      <= 1'b0;
      q.resume   <= 1'b0;
    end else begin
      q <= d;
    end
  end

  // ------------------------------------------------------------
  // Outputs
  // ------------------------------------------------------------
  assign reg_rdata_out            = q.rdata;
  assign mode_out                 = q.mode;
  assign cpu_run_out              = (q.mode == SCSC_NORMAL);
  assign wdt_run_out              = (q.mode == SCSC_NORMAL);
  assign periph_run_out           = clocks_run;
  assign osc_enable_out           = (q.mode != SCSC_STOP);
  assign port_hiz_out             = (q.mode == SCSC_STOP) &&
                                    !q.sby1[SCSC_SBY1_HOLD];
  assign service_irq_out          = q.svc;
  assign resume_next_out          = q.resume;
  assign machine_state_out        = q.mstate;
  assign divider_output_pulse_out = q.divider_output_pulse;
  assign tb_src_out               = q.tb_src;
  assign wdt_src_out              = q.wdt_src;
  assign tmr_src_out              = q.tmr_src;
  assign warmup_clk_out           = q.wup_clk;

endmodule

// File: logic/scsc_pkg.sv
package scsc_pkg;

  // ------------------------------------------------------------
  // Register map
  // ------------------------------------------------------------
  localparam logic [7:0] SCSC_ADDR_DIVCTL = 8'h35;
  localparam logic [7:0] SCSC_ADDR_TBDIV  = 8'h36;
  localparam logic [7:0] SCSC_ADDR_SBY1   = 8'h38;
  localparam logic [7:0] SCSC_ADDR_SBY2   = 8'h39;

  localparam logic [7:0] SCSC_RST_DIVCTL = 8'h00;
  localparam logic [7:0] SCSC_RST_TBDIV  = 8'h00;
  localparam logic [7:0] SCSC_RST_SBY1   = 8'h00;
  localparam logic [7:0] SCSC_RST_SBY2   = 8'h80;

  // Writable bits of each register, readable bits of all but TBDIV
  localparam logic [7:0] SCSC_WM_DIVCTL = 8'h20;
  localparam logic [7:0] SCSC_WM_TBDIV  = 8'hef;
  localparam logic [7:0] SCSC_WM_SBY1   = 8'hfc;
  localparam logic [7:0] SCSC_WM_SBY2   = 8'hb0;
  localparam logic [7:0] SCSC_RM_DIVCTL = 8'he7;
  localparam logic [7:0] SCSC_RM_SBY1   = 8'hfc;
  localparam logic [7:0] SCSC_RM_SBY2   = 8'hf0;

  // ------------------------------------------------------------
  // Field positions
  // ------------------------------------------------------------
  localparam int SCSC_SBY1_STOP   = 7;
  localparam int SCSC_SBY1_RELSEL = 6;
  localparam int SCSC_SBY1_RETSEL = 5;
  localparam int SCSC_SBY1_HOLD   = 4;
  localparam int SCSC_SBY1_WUT    = 2;
  localparam int SCSC_SBY2_IDLE   = 4;
  localparam int SCSC_DIV_STAGE   = 5;
  localparam int SCSC_TB_DIVIDER_OUTPUT_ENABLE    = 7;
  localparam int SCSC_TB_DVORATE  = 5;
  localparam int SCSC_TB_EN       = 3;
  localparam int SCSC_TB_RATE     = 0;

  // ------------------------------------------------------------
  // Timing generator
  // ------------------------------------------------------------
  localparam int SCSC_FC_HZ    = 10_000_000;
  localparam int SCSC_PRE_W    = 3;
  localparam int SCSC_DIV_W    = 21;
  localparam int SCSC_CHAIN_W  = SCSC_PRE_W + SCSC_DIV_W;
  localparam int SCSC_WUP_LONG  = 3 * (2 ** 16);
  localparam int SCSC_WUP_MID   = 2 ** 16;
  localparam int SCSC_WUP_SHORT = 2 ** 14;
  localparam int SCSC_TAP_TB   = 8;
  localparam int SCSC_TAP_DVO  = 10;
  localparam int SCSC_TAP_WDT  = 12;
  localparam int SCSC_TAP_TMR  = 4;

  typedef enum logic [1:0] {
    SCSC_NORMAL = 2'b00,
    SCSC_IDLE   = 2'b01,
    SCSC_STOP   = 2'b10,
    SCSC_WARMUP = 2'b11
  } scsc_mode_e;

endpackage

// File: verification/scsc_sva.sv
`timescale 1ns/1ns
module scsc_sva
  import scsc_pkg::*;
(
  // Clock and reset
  input wire logic       clk_sys_in,
  input wire logic       rst_n_in,
  // Watched ports
  input wire logic       reg_rd_in,
  input wire logic [7:0] reg_rdata_out,
  input wire logic       stop_release_pin_in,
  input wire logic       irq_in,
  input wire logic       master_interrupt_enable_in,
  input wire logic [1:0] mode_out,
  input wire logic       cpu_run_out,
  input wire logic       wdt_run_out,
  input wire logic       periph_run_out,
  input wire logic       osc_enable_out,
  input wire logic       port_hiz_out,
  input wire logic       service_irq_out,
  input wire logic       resume_next_out,
  input wire logic [1:0] machine_state_out,
  input wire logic       warmup_clk_out
);
  default clocking @(posedge clk_sys_in); endclocking
  default disable iff (!rst_n_in);
  a_run_decode: assert property (cpu_run_out == (mode_out == SCSC_NORMAL)
    && wdt_run_out == cpu_run_out) else $error("core run decode wrong");
  a_periph_run: assert property (periph_run_out == (mode_out inside {SCSC_NORMAL, SCSC_IDLE}))
    else $error("peripheral run decode wrong");
  a_osc_stop: assert property (osc_enable_out == (mode_out != SCSC_STOP))
    else $error("oscillator enable wrong");
  a_state_step: assert property (mode_out inside {SCSC_NORMAL, SCSC_IDLE} && $past(rst_n_in)
    && $past(mode_out) inside {SCSC_NORMAL, SCSC_IDLE}
    |-> machine_state_out == $past(machine_state_out) + 2'h1) else $error("state skipped");
  a_stop_hold: assert property (mode_out == SCSC_STOP && !stop_release_pin_in
    |=> mode_out == SCSC_STOP) else $error("stop left without pin");
  a_edge_release: assert property (mode_out == SCSC_STOP && stop_release_pin_in
    && !$past(stop_release_pin_in) |=> mode_out == SCSC_WARMUP) else $error("edge ignored");
  a_warmup_min: assert property ($rose(mode_out == SCSC_WARMUP)
    |-> (mode_out == SCSC_WARMUP) [*4]) else $error("warm-up too short");
  a_warmup_max: assert property (mode_out == SCSC_WARMUP
    |-> ##[1:24] mode_out != SCSC_WARMUP) else $error("warm-up too long");
  a_warmup_exit: assert property ($fell(mode_out == SCSC_WARMUP) && $past(rst_n_in)
    |-> mode_out == SCSC_NORMAL && resume_next_out) else $error("bad warm-up exit");
  a_idle_exit: assert property (mode_out == SCSC_IDLE && irq_in |=> mode_out == SCSC_NORMAL
    && service_irq_out == $past(master_interrupt_enable_in)
    && resume_next_out != service_irq_out) else $error("bad idle exit");
  a_hiz_stop: assert property (port_hiz_out |-> mode_out == SCSC_STOP)
    else $error("ports released outside stop");
  a_rdata_idle: assert property (!$past(reg_rd_in) |-> reg_rdata_out == 8'h00)
    else $error("read data outside its cycle");
  a_warmup_clock: assert property (warmup_clk_out == $past(mode_out == SCSC_WARMUP))
    else $error("warm-up clock wrong");
  c_stop_rel: cover property (mode_out == SCSC_STOP ##1 mode_out == SCSC_WARMUP);
  c_idle_svc: cover property (service_irq_out);
  c_warm_end: cover property ($fell(mode_out == SCSC_WARMUP));
endmodule

// File: verification/scsc_pin_model.sv
`timescale 1ns/1ns
// Stop-release pin driver: after go_in waits wait_in+2 cycles, then
// drives the pin high for three cycles; lvl_in holds it high.
// The pin rests low between pulses, as a pulled-down line would.
module scsc_pin_model (
  input  wire logic       clk_in,
  input  wire logic       go_in,
  input  wire logic       lvl_in,
  input  wire logic [3:0] wait_in,
  output logic            pin_out
);
  logic [4:0] cnt_q = 5'h00;
  initial pin_out = 1'b0;
  always @(posedge clk_in) begin
    cnt_q <= go_in ? {1'b0, wait_in} + 5'h05 : (cnt_q != 5'h00 ? cnt_q - 5'h01 : 5'h00);
    pin_out <= lvl_in || (cnt_q inside {5'h02, 5'h03, 5'h04});
  end
endmodule

// File: verification/testbench.sv
`timescale 1ns/1ns
module testbench;
  import scsc_pkg::*;
  localparam int WL = 12, WM = 8, WS = 4;
  localparam int WIN = 1 << (SCSC_TAP_WDT + 1);
  logic       clk_sys_in = 1'b0, rst_n_in = 1'b0;
  logic [7:0] addr = 8'h00, wdat = 8'h00, rdat, d, v;
  logic       wr = 1'b0, rd = 1'b0, irq = 1'b0, mie = 1'b0, go = 1'b0, lvl = 1'b0;
  logic [3:0] dly = 4'h0;
  logic       pin, cpu, wdt, per, osc, hiz, svc, rsm;
  logic       divider_output_pulse, tbs, wds, tmr, wclk, dvo_prev;
  logic [1:0] mode;
  logic [31:0] seed = 32'hbb7857b8;
  int         miscompares = 0, n_checks = 0, n, nw;
  int         cnt [4];
  logic [7:0] ra [4] = '{SCSC_ADDR_DIVCTL, SCSC_ADDR_TBDIV, SCSC_ADDR_SBY1, SCSC_ADDR_SBY2};
  logic [7:0] sm [4] = '{8'h38, 8'hef, 8'h5f, 8'h0f};
  logic [7:0] em [4] = '{SCSC_WM_DIVCTL & SCSC_RM_DIVCTL, SCSC_WM_TBDIV,
                         SCSC_WM_SBY1 & SCSC_RM_SBY1, SCSC_WM_SBY2 & SCSC_RM_SBY2};
  scsc_top #(.WUP_LONG_CYC(WL), .WUP_MID_CYC(WM), .WUP_SHORT_CYC(WS)) i_dut (
    .clk_sys_in(clk_sys_in), .rst_n_in(rst_n_in), .reg_addr_in(addr),
    .reg_wdata_in(wdat), .reg_wr_in(wr), .reg_rd_in(rd), .reg_rdata_out(rdat),
    .stop_release_pin_in(pin), .irq_in(irq), .master_interrupt_enable_in(mie),
    .mode_out(mode), .cpu_run_out(cpu), .wdt_run_out(wdt), .periph_run_out(per),
    .osc_enable_out(osc), .port_hiz_out(hiz), .service_irq_out(svc),
    .resume_next_out(rsm), .machine_state_out(), .divider_output_pulse_out(divider_output_pulse),
    .tb_src_out(tbs), .wdt_src_out(wds), .tmr_src_out(tmr), .warmup_clk_out(wclk));
  scsc_pin_model i_pin (.clk_in(clk_sys_in), .go_in(go), .lvl_in(lvl), .wait_in(dly),
    .pin_out(pin));
  always #50 clk_sys_in = ~clk_sys_in;
  function automatic logic [31:0] xs(input logic [31:0] s);
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    return s ^ (s << 5);
  endfunction
  function automatic logic [7:0] wup(input logic [1:0] w, input logic s);
    int k;
    k = (w == 2'b01) ? WM : (w == 2'b10) ? WS : WL;
    return 8'(s ? 2 * k : k);
  endfunction
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
    n_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("MISMATCH %0t %s", $time, m);
    end
  endtask
  task automatic wr_reg(input logic [7:0] a, input logic [7:0] x);
    @(posedge clk_sys_in);
    addr <= a;
    wdat <= x;
    wr <= 1'b1;
    @(posedge clk_sys_in);
    wr <= 1'b0;
  endtask
  task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
    @(posedge clk_sys_in);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk_sys_in);
    rd <= 1'b0;
    @(negedge clk_sys_in);
    chk(rdat, e, "read data");
  endtask
  task automatic wait_mode(input logic [1:0] m);
    int k;
    k = 0;
    do begin
      @(negedge clk_sys_in);
      k++;
    end while (mode !== m && k < 200);
    chk(8'(mode), 8'(m), "mode");
  endtask
  task automatic end_sim;
    if (miscompares == 0 && n_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  initial begin
    repeat (6) @(posedge clk_sys_in);
    rst_n_in <= 1'b1;
    @(negedge clk_sys_in);
    chk({mode, cpu, per, osc}, {SCSC_NORMAL, 3'b111}, "reset mode");
    chk(8'(hiz), 8'h00, "reset ports");
    for (int k = 0; k < 4; k++) begin
      rd_chk(ra[k], k == 3 ? 8'h80 : 8'h00);
      repeat (3) begin
        seed = xs(seed);
        d = (seed[7:0] & sm[k]) | (k == 3 ? 8'h80 : 8'h00);
        wr_reg(ra[k], d);
        rd_chk(ra[k], d & em[k]);
      end
    end
    wr_reg(8'h37, 8'hff);
    rd_chk(8'h37, 8'h00);
    for (int j = 0; j < 2; j++) begin
      wr_reg(SCSC_ADDR_TBDIV, j[0] ? 8'haa : 8'h88);
      mie <= j[0];
      wr_reg(SCSC_ADDR_SBY2, 8'h90);
      wait_mode(SCSC_IDLE);
      chk({cpu, wdt, per}, 3'b001, "idle run");
      // Whole periods of every tap fit the window, so counts are phase free
      cnt = '{0, 0, 0, 0};
      dvo_prev = divider_output_pulse;
      for (int t = 0; t < WIN; t++) begin
        @(negedge clk_sys_in);
        cnt[0] += tmr;
        cnt[1] += tbs;
        cnt[2] += (divider_output_pulse != dvo_prev);
        cnt[3] += wds + wclk;
        dvo_prev = divider_output_pulse;
      end
      chk(cnt[0], WIN >> (SCSC_TAP_TMR + 1), "timer source count");
      chk(cnt[1], WIN >> (SCSC_TAP_TB + 1 + 2 * j), "time base count");
      chk(cnt[2], WIN >> (SCSC_TAP_DVO + 1 + j), "divider output toggles");
      chk(cnt[3], 0, "watchdog or warm-up clock in idle");
      @(posedge clk_sys_in);
      irq <= 1'b1;
      @(posedge clk_sys_in);
      irq <= 1'b0;
      @(negedge clk_sys_in);
      chk({mode, svc, rsm}, {SCSC_NORMAL, j[0], !j[0]}, "idle exit");
      rd_chk(SCSC_ADDR_SBY2, 8'h80);
    end
    for (int i = 0; i < 8; i++) begin
      v = {1'b1, i[1], 1'b0, i[0] ^ i[2], i[2:1], 2'b00};
      wr_reg(SCSC_ADDR_DIVCTL, {2'b00, i[0], 5'h00});
      wr_reg(SCSC_ADDR_SBY1, v);
      wait_mode(SCSC_STOP);
      chk({osc, hiz}, {1'b0, !v[4]}, "stop pins");
      seed = xs(seed);
      @(posedge clk_sys_in);
      dly <= seed[3:0];
      go <= 1'b1;
      @(posedge clk_sys_in);
      go <= 1'b0;
      wait_mode(SCSC_WARMUP);
      chk({cpu, per, osc}, 3'b001, "warm-up halt");
      n = 0;
      nw = 0;
      while (mode === SCSC_WARMUP && n < 100) begin
        @(negedge clk_sys_in);
        n++;
        nw += wclk;
      end
      chk(8'(n), wup(i[2:1], i[0]), "warm-up length");
      chk(nw, wup(i[2:1], i[0]), "warm-up clock count");
      chk({mode, rsm}, {SCSC_NORMAL, 1'b1}, "warm-up end");
      rd_chk(SCSC_ADDR_SBY1, v & 8'h7c);
    end
    @(posedge clk_sys_in);
    lvl <= 1'b1;
    wr_reg(SCSC_ADDR_SBY1, 8'hd0);
    repeat (2) @(negedge clk_sys_in);
    chk(8'(mode), 8'(SCSC_WARMUP), "stop skipped");
    @(posedge clk_sys_in);
    lvl <= 1'b0;
    wait_mode(SCSC_NORMAL);
    wr_reg(SCSC_ADDR_SBY1, 8'h90);
    wait_mode(SCSC_STOP);
    @(posedge clk_sys_in);
    rst_n_in <= 1'b0;
    repeat (2) @(posedge clk_sys_in);
    rst_n_in <= 1'b1;
    @(negedge clk_sys_in);
    chk({mode, osc}, {SCSC_NORMAL, 1'b1}, "reset from stop");
    rd_chk(SCSC_ADDR_SBY1, 8'h00);
    end_sim;
  end
  initial begin
    #3000000;
    miscompares++;
    end_sim;
  end
endmodule
bind scsc_top scsc_sva i_sva (.clk_sys_in(clk_sys_in), .rst_n_in(rst_n_in),
  .reg_rd_in(reg_rd_in), .reg_rdata_out(reg_rdata_out),
  .stop_release_pin_in(stop_release_pin_in), .irq_in(irq_in),
  .master_interrupt_enable_in(master_interrupt_enable_in), .mode_out(mode_out),
  .cpu_run_out(cpu_run_out), .wdt_run_out(wdt_run_out), .periph_run_out(periph_run_out),
  .osc_enable_out(osc_enable_out), .port_hiz_out(port_hiz_out),
  .service_irq_out(service_irq_out), .resume_next_out(resume_next_out),
  .machine_state_out(machine_state_out), .warmup_clk_out(warmup_clk_out));
